// file: rtl/pif_cfg.svh
// Register map, field positions and reset values of the peripheral interrupt flag block.
`ifndef PIF_CFG_SVH
`define PIF_CFG_SVH

`define PIF_ADDR_W      12
`define PIF_OFF_FLAG1   12'h000
`define PIF_OFF_FLAG2   12'h004
`define PIF_OFF_EN1     12'h008
`define PIF_OFF_EN2     12'h00C
`define PIF_OFF_CTRL    12'h010
`define PIF_OFF_STAT    12'h014

`define PIF_RST8        8'h00
`define PIF_RST32       32'h00000000
`define PIF_F1_W        3

`define PIF_B_T1OVF     0
`define PIF_B_T2MAT     1
`define PIF_B_CC1       2
`define PIF_B_CC2       0
`define PIF_B_T3OVF     1
`define PIF_B_VDET      2
`define PIF_B_BCOL      3
`define PIF_B_NVWR      4
`define PIF_B_USB       5
`define PIF_B_CMP       6
`define PIF_B_OSCF      7
`define PIF_B_ADC_EN    6
`define PIF_B_PAR_EN    7

`define PIF_C_GLB       0
`define PIF_C_GATE      1
`define PIF_C_PRIO      2
`define PIF_C_T3SEL     3
`define PIF_C_M1_LO     4
`define PIF_C_M1_HI     5
`define PIF_C_M2_LO     6
`define PIF_C_M2_HI     7

`define PIF_S_IRQ       0
`define PIF_S_NVBUSY    1
`define PIF_S_CMP       2

`endif

// file: rtl/pif_pkg.sv
// Types of the peripheral interrupt flag block.
package pif_pkg;

	typedef enum logic [1:0] {
		PIF_CAPTURE = 2'b00,
		PIF_COMPARE = 2'b01,
		PIF_PWM     = 2'b10,
		PIF_OFF     = 2'b11
	} pif_mode_t;

	typedef struct packed {
		logic [2:0]  flag1;
		logic [7:0]  flag2;
		logic [7:0]  en1;
		logic [7:0]  en2;
		logic        glb_en;
		logic        gate;
		logic        prio_on;
		logic        t3_sel;
		pif_mode_t   mode1;
		pif_mode_t   mode2;
		logic        cmp_prev;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
	} pif_state_t;

endpackage

// file: rtl/pif_flags.sv
// Peripheral interrupt flag and enable registers with an APB slave and the request gate.
//
// Functional notes
// [RULE_01] Capcomp one compare match sets its flag.
// [RULE_02] Capcomp flags take no events in PWM.
// [RULE_03] Timer two period match sets its flag.
// [RULE_04] Timer one rollover sets its flag.
// [RULE_05] Software keeps parallel flag clear, small package.
// [RULE_06] Oscillator failover sets flag, software clears.
// [RULE_07] Any comparator input change sets flag.
// [RULE_08] USB engine request sets its flag.
// [RULE_09] Write done sets; pending write reads zero.
// [RULE_10] Serial bus collision sets its flag.
// [RULE_11] Voltage detector condition sets its flag.
// [RULE_12] Timer three rollover sets its flag.
// [RULE_13] Capcomp two capture sets its flag.
// [RULE_14] Capcomp two selected timer match sets flag.
// [RULE_15] Without priorities, peripheral gate also required.
// [RULE_16] Enable bit seven allows parallel port interrupt.
// [RULE_17] Enable bit six allows converter interrupt.
// [RULE_18] Flags set regardless of any enable.
// [RULE_19] Peripheral gate allows or blocks all requests. With priorities on, the global enable alone passes them too.
// [RULE_20] Request when flag and enable both set.
`timescale 1ns/10ps
`include "pif_cfg.svh"

module pif_flags
	import pif_pkg::*;
(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`PIF_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    timer_one_rollover,
	input  wire logic                    timer_two_period_match,
	input  wire logic                    capcomp_one_match,
	input  wire logic                    capcomp_one_capture,
	input  wire logic                    osc_fail_event,
	input  wire logic                    comparator_level,
	input  wire logic                    usb_request,
	input  wire logic                    nv_write_busy,
	input  wire logic                    nv_write_done,
	input  wire logic                    bus_collision,
	input  wire logic                    voltage_detect,
	input  wire logic                    timer_three_rollover,
	input  wire logic                    capcomp_two_capture,
	input  wire logic                    capcomp_two_match_t1,
	input  wire logic                    capcomp_two_match_t3,
	input  wire logic                    parallel_port_pending,
	input  wire logic                    adc_pending,
	output logic                         periph_irq
);

	pif_state_t s_ff;
	pif_state_t nxt_s;

	logic       acc_done;
	logic       wr_done;
	logic       setup;
	logic       wr_f1;
	logic       wr_f2;
	logic       wr_en1;
	logic       wr_en2;
	logic       wr_ctrl;
	logic       cc2_match;
	logic [7:0] set2;
	logic [2:0] set1;

	// Address compare shared by the read mux and the write strobes.
	function automatic logic fn_hit(input logic [`PIF_ADDR_W-1:0] a, input logic [`PIF_ADDR_W-1:0] off);
		fn_hit = (a == off);
	endfunction

	function automatic logic fn_mapped(input logic [`PIF_ADDR_W-1:0] a);
		fn_mapped = fn_hit(a, `PIF_OFF_FLAG1) | fn_hit(a, `PIF_OFF_FLAG2) | fn_hit(a, `PIF_OFF_EN1) |
			fn_hit(a, `PIF_OFF_EN2) | fn_hit(a, `PIF_OFF_CTRL) | fn_hit(a, `PIF_OFF_STAT);
	endfunction

	// A transfer completes in the access cycle that follows its setup cycle.
	assign setup     = psel & ~penable;
	assign acc_done  = psel & penable & s_ff.pready;
	assign wr_done   = acc_done & pwrite & fn_mapped(paddr);
	assign wr_f1     = wr_done & fn_hit(paddr, `PIF_OFF_FLAG1);
	assign wr_f2     = wr_done & fn_hit(paddr, `PIF_OFF_FLAG2);
	assign wr_en1    = wr_done & fn_hit(paddr, `PIF_OFF_EN1);
	assign wr_en2    = wr_done & fn_hit(paddr, `PIF_OFF_EN2);
	assign wr_ctrl   = wr_done & fn_hit(paddr, `PIF_OFF_CTRL);

	// Hardware set terms; enables are not consulted here. [RULE_18]
	assign set1[`PIF_B_T1OVF] = timer_one_rollover;                                    // [RULE_04]
	assign set1[`PIF_B_T2MAT] = timer_two_period_match;                                // [RULE_03]
	assign set1[`PIF_B_CC1]   = (s_ff.mode1 == PIF_COMPARE & capcomp_one_match) |      // [RULE_01] [RULE_02]
		(s_ff.mode1 == PIF_CAPTURE & capcomp_one_capture);
	assign cc2_match = s_ff.t3_sel ? capcomp_two_match_t3 : capcomp_two_match_t1;      // [RULE_14]
	assign set2[`PIF_B_CC2]   = (s_ff.mode2 == PIF_CAPTURE & capcomp_two_capture) |    // [RULE_13] [RULE_02]
		(s_ff.mode2 == PIF_COMPARE & cc2_match);                                         // [RULE_14]
	assign set2[`PIF_B_T3OVF] = timer_three_rollover;                                  // [RULE_12]
	assign set2[`PIF_B_VDET]  = voltage_detect;                                        // [RULE_11]
	assign set2[`PIF_B_BCOL]  = bus_collision;                                         // [RULE_10]
	assign set2[`PIF_B_NVWR]  = nv_write_done;                                         // [RULE_09]
	assign set2[`PIF_B_USB]   = usb_request;                                           // [RULE_08]
	assign set2[`PIF_B_CMP]   = comparator_level ^ s_ff.cmp_prev;                      // [RULE_07]
	assign set2[`PIF_B_OSCF]  = osc_fail_event;                                        // [RULE_06]

	always_comb begin
		logic [2:0]  base1;
		logic [7:0]  base2;
		logic        pend;
		logic        gate_ok;
		logic [31:0] rd;
		base1 = s_ff.flag1;
		base2 = s_ff.flag2;
		pend = 1'b0;
		gate_ok = 1'b0;
		rd = `PIF_RST32;
		nxt_s = s_ff;

		// Software writes take effect only at the completing edge; a set in that cycle wins.
		if (wr_f1) begin
			base1 = pwdata[`PIF_F1_W-1:0];
		end
		if (wr_f2) begin
			base2 = pwdata[7:0];
		end
		nxt_s.flag1 = base1 | set1;                                                    // [RULE_01] [RULE_03] [RULE_04]
		nxt_s.flag2 = base2 | set2;                                                    // [RULE_06] [RULE_07] [RULE_08]
		// A pending write forces the done flag low until the write ends.
		nxt_s.flag2[`PIF_B_NVWR] = (base2[`PIF_B_NVWR] & ~nv_write_busy) | nv_write_done; // [RULE_09]
		nxt_s.cmp_prev = comparator_level;

		if (wr_en1) begin
			nxt_s.en1 = pwdata[7:0];                                                   // [RULE_16] [RULE_17]
		end
		if (wr_en2) begin
			nxt_s.en2 = pwdata[7:0];
		end
		if (wr_ctrl) begin
			nxt_s.glb_en  = pwdata[`PIF_C_GLB];
			nxt_s.gate    = pwdata[`PIF_C_GATE];
			nxt_s.prio_on = pwdata[`PIF_C_PRIO];
			nxt_s.t3_sel  = pwdata[`PIF_C_T3SEL];
			nxt_s.mode1   = pif_mode_t'(pwdata[`PIF_C_M1_HI:`PIF_C_M1_LO]);
			nxt_s.mode2   = pif_mode_t'(pwdata[`PIF_C_M2_HI:`PIF_C_M2_LO]);
		end

		// Same-position flag and enable pairs, plus the two externally held requests.
		pend = (|(s_ff.flag1 & s_ff.en1[`PIF_F1_W-1:0])) | (|(s_ff.flag2 & s_ff.en2)) | // [RULE_20]
			(parallel_port_pending & s_ff.en1[`PIF_B_PAR_EN]) |                          // [RULE_16]
			(adc_pending & s_ff.en1[`PIF_B_ADC_EN]);                                     // [RULE_17]
		if (s_ff.prio_on) begin
			gate_ok = s_ff.glb_en | s_ff.gate;
		end else begin
			gate_ok = s_ff.glb_en & s_ff.gate;                                         // [RULE_15] [RULE_19]
		end
		nxt_s.irq = pend & gate_ok;                                                    // [RULE_20]

		// Read data is captured in the setup cycle and stands through the access cycle.
		if (fn_hit(paddr, `PIF_OFF_FLAG1)) begin
			rd[`PIF_F1_W-1:0] = s_ff.flag1;
		end else if (fn_hit(paddr, `PIF_OFF_FLAG2)) begin
			rd[7:0] = s_ff.flag2;
		end else if (fn_hit(paddr, `PIF_OFF_EN1)) begin
			rd[7:0] = s_ff.en1;
		end else if (fn_hit(paddr, `PIF_OFF_EN2)) begin
			rd[7:0] = s_ff.en2;
		end else if (fn_hit(paddr, `PIF_OFF_CTRL)) begin
			rd[`PIF_C_GLB]   = s_ff.glb_en;
			rd[`PIF_C_GATE]  = s_ff.gate;
			rd[`PIF_C_PRIO]  = s_ff.prio_on;
			rd[`PIF_C_T3SEL] = s_ff.t3_sel;
			rd[`PIF_C_M1_HI:`PIF_C_M1_LO] = s_ff.mode1;
			rd[`PIF_C_M2_HI:`PIF_C_M2_LO] = s_ff.mode2;
		end else if (fn_hit(paddr, `PIF_OFF_STAT)) begin
			rd[`PIF_S_IRQ]    = s_ff.irq;
			rd[`PIF_S_NVBUSY] = nv_write_busy;
			rd[`PIF_S_CMP]    = comparator_level;
		end
		if (setup) begin
			nxt_s.pready  = 1'b1;
			nxt_s.prdata  = pwrite ? `PIF_RST32 : rd;
			nxt_s.pslverr = ~fn_mapped(paddr);
		end else begin
			nxt_s.pready  = 1'b0;
			nxt_s.prdata  = `PIF_RST32;
			nxt_s.pslverr = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff.flag1    <= `PIF_F1_W'(0);
			s_ff.flag2    <= `PIF_RST8;
			s_ff.en1      <= `PIF_RST8;
			s_ff.en2      <= `PIF_RST8;
			s_ff.glb_en   <= 1'b0;
			s_ff.gate     <= 1'b0;
			s_ff.prio_on  <= 1'b0;
			s_ff.t3_sel   <= 1'b0;
			s_ff.mode1    <= PIF_OFF;
			s_ff.mode2    <= PIF_OFF;
			s_ff.cmp_prev <= 1'b0;
			s_ff.prdata   <= `PIF_RST32;
			s_ff.pready   <= 1'b0;
			s_ff.pslverr  <= 1'b0;
			s_ff.irq      <= 1'b0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign prdata     = s_ff.prdata;
	assign pready     = s_ff.pready;
	assign pslverr    = s_ff.pslverr;
	assign periph_irq = s_ff.irq;

	property p_cc1_compare;
		@(posedge pclk) disable iff (!presetn)
		(s_ff.mode1 == PIF_COMPARE && capcomp_one_match) |=> s_ff.flag1[`PIF_B_CC1];
	endproperty
	a_cc1_compare: assert property (p_cc1_compare) else $error("capcomp one flag not set on match"); // [RULE_01]

	property p_cc1_pwm_quiet;
		@(posedge pclk) disable iff (!presetn)
		(s_ff.mode1 == PIF_PWM && !wr_f1 && !s_ff.flag1[`PIF_B_CC1]) |=> !s_ff.flag1[`PIF_B_CC1];
	endproperty
	a_cc1_pwm_quiet: assert property (p_cc1_pwm_quiet) else $error("capcomp one flag set in pwm"); // [RULE_02]

	property p_cc2_pwm_quiet;
		@(posedge pclk) disable iff (!presetn)
		(s_ff.mode2 == PIF_PWM && !wr_f2 && !s_ff.flag2[`PIF_B_CC2]) |=> !s_ff.flag2[`PIF_B_CC2];
	endproperty
	a_cc2_pwm_quiet: assert property (p_cc2_pwm_quiet) else $error("capcomp two flag set in pwm"); // [RULE_02]

	property p_t2_match;
		@(posedge pclk) disable iff (!presetn)
		timer_two_period_match |=> s_ff.flag1[`PIF_B_T2MAT];
	endproperty
	a_t2_match: assert property (p_t2_match) else $error("timer two match flag missed"); // [RULE_03]

	property p_t1_hold;
		@(posedge pclk) disable iff (!presetn)
		(s_ff.flag1[`PIF_B_T1OVF] && !wr_f1) |=> s_ff.flag1[`PIF_B_T1OVF];
	endproperty
	a_t1_hold: assert property (p_t1_hold) else $error("timer one flag dropped without a write"); // [RULE_04]

	property p_osc_fail;
		@(posedge pclk) disable iff (!presetn)
		osc_fail_event ##1 (!wr_f2) |=> s_ff.flag2[`PIF_B_OSCF];
	endproperty
	a_osc_fail: assert property (p_osc_fail) else $error("oscillator fail flag lost"); // [RULE_06]

	property p_cmp_change;
		@(posedge pclk) disable iff (!presetn)
		(comparator_level != $past(comparator_level)) |=> s_ff.flag2[`PIF_B_CMP];
	endproperty
	a_cmp_change: assert property (p_cmp_change) else $error("comparator change not flagged"); // [RULE_07]

	property p_usb;
		@(posedge pclk) disable iff (!presetn)
		usb_request |=> s_ff.flag2[`PIF_B_USB];
	endproperty
	a_usb: assert property (p_usb) else $error("usb flag not set"); // [RULE_08]

	property p_nv_busy;
		@(posedge pclk) disable iff (!presetn)
		(nv_write_busy && !nv_write_done) |=> !s_ff.flag2[`PIF_B_NVWR];
	endproperty
	a_nv_busy: assert property (p_nv_busy) else $error("write done flag high while busy"); // [RULE_09]

	property p_bcol;
		@(posedge pclk) disable iff (!presetn)
		bus_collision |=> s_ff.flag2[`PIF_B_BCOL];
	endproperty
	a_bcol: assert property (p_bcol) else $error("bus collision flag not set"); // [RULE_10]

	property p_vdet;
		@(posedge pclk) disable iff (!presetn)
		voltage_detect |=> s_ff.flag2[`PIF_B_VDET];
	endproperty
	a_vdet: assert property (p_vdet) else $error("voltage detect flag not set"); // [RULE_11]

	property p_t3;
		@(posedge pclk) disable iff (!presetn)
		timer_three_rollover |=> s_ff.flag2[`PIF_B_T3OVF];
	endproperty
	a_t3: assert property (p_t3) else $error("timer three flag not set"); // [RULE_12]

	property p_cc2_capture;
		@(posedge pclk) disable iff (!presetn)
		(s_ff.mode2 == PIF_CAPTURE && capcomp_two_capture) |=> s_ff.flag2[`PIF_B_CC2];
	endproperty
	a_cc2_capture: assert property (p_cc2_capture) else $error("capcomp two capture missed"); // [RULE_13]

	property p_cc2_select;
		@(posedge pclk) disable iff (!presetn)
		(s_ff.mode2 == PIF_COMPARE && s_ff.t3_sel && capcomp_two_match_t3) |=> s_ff.flag2[`PIF_B_CC2];
	endproperty
	a_cc2_select: assert property (p_cc2_select) else $error("capcomp two timer three match missed"); // [RULE_14]

	property p_gate_block;
		@(posedge pclk) disable iff (!presetn)
		(!s_ff.prio_on && !s_ff.gate) |=> !periph_irq;
	endproperty
	a_gate_block: assert property (p_gate_block) else $error("request passed with gate closed"); // [RULE_15]

	property p_adc_en;
		@(posedge pclk) disable iff (!presetn)
		(adc_pending && s_ff.en1 == `PIF_RST8 && s_ff.en2 == `PIF_RST8) |=> !periph_irq;
	endproperty
	a_adc_en: assert property (p_adc_en) else $error("converter request passed while disabled"); // [RULE_17]

	property p_par_en;
		@(posedge pclk) disable iff (!presetn)
		(parallel_port_pending && s_ff.en1[`PIF_B_PAR_EN] && s_ff.glb_en && s_ff.gate) |=> periph_irq;
	endproperty
	a_par_en: assert property (p_par_en) else $error("parallel port request not passed"); // [RULE_16]

	property p_poll;
		@(posedge pclk) disable iff (!presetn)
		(timer_one_rollover && !s_ff.glb_en && !s_ff.prio_on) |=> s_ff.flag1[`PIF_B_T1OVF] && !periph_irq;
	endproperty
	a_poll: assert property (p_poll) else $error("flag not pollable with enables off"); // [RULE_18] [RULE_19]

	property p_irq_pair;
		@(posedge pclk) disable iff (!presetn)
		(s_ff.flag2[`PIF_B_USB] && s_ff.en2[`PIF_B_USB] && s_ff.glb_en && s_ff.gate) |=> periph_irq;
	endproperty
	a_irq_pair: assert property (p_irq_pair) else $error("enabled flag raised no request"); // [RULE_20]

	property p_apb_one_wait;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready ##1 !pready;
	endproperty
	a_apb_one_wait: assert property (p_apb_one_wait) else $error("apb ready not one cycle after setup");

endmodule

// file: dv/pif_periph_model.sv
// Behavioural model of the on-chip peripherals that raise interrupt conditions.
`timescale 1ns/10ps

module pif_periph_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        fire,
	input  wire logic [4:0]  sel,
	output logic      [12:0] ev,
	output logic             cmp_lvl,
	output logic             nv_busy,
	output logic             par_pend,
	output logic             adc_pend
);
	// Commands 0 to 12 pulse one event line for a single cycle; 13 to 16 toggle a level line.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev       <= 13'h0000;
			cmp_lvl  <= 1'b0;
			nv_busy  <= 1'b0;
			par_pend <= 1'b0;
			adc_pend <= 1'b0;
		end else begin
			ev <= (fire && sel < 5'h0D) ? (13'h0001 << sel) : 13'h0000;
			if (fire) begin
				cmp_lvl  <= cmp_lvl ^ (sel == 5'h0D);
				nv_busy  <= nv_busy ^ (sel == 5'h0E);
				par_pend <= par_pend ^ (sel == 5'h0F);
				adc_pend <= adc_pend ^ (sel == 5'h10);
			end
		end
	end
endmodule

// file: dv/pif_flags_test.sv
// Self-checking testbench of the peripheral interrupt flag block.
`timescale 1ns/10ps
`include "pif_cfg.svh"

module pif_flags_test;
	import pif_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        periph_irq;
	logic        fire;
	logic [4:0]  sel;
	logic [12:0] ev;
	logic        cmp_lvl;
	logic        nv_busy;
	logic        par_pend;
	logic        adc_pend;
	logic [31:0] rdat;
	logic        rerr;
	int          n_mismatch;
	int          n_compared;
	// Expected flag mask per command; zero where the current capcomp mode must ignore the event.
	localparam logic [7:0] MSK [14] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h80, 8'h20, 8'h10,
		8'h08, 8'h04, 8'h02, 8'h01, 8'h00, 8'h00, 8'h40};

	pif_periph_model PM (.pclk(pclk), .presetn(presetn), .fire(fire), .sel(sel), .ev(ev),
		.cmp_lvl(cmp_lvl), .nv_busy(nv_busy), .par_pend(par_pend), .adc_pend(adc_pend));

	pif_flags DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_one_rollover(ev[0]), .timer_two_period_match(ev[1]), .capcomp_one_match(ev[2]),
		.capcomp_one_capture(ev[3]), .osc_fail_event(ev[4]), .comparator_level(cmp_lvl),
		.usb_request(ev[5]), .nv_write_busy(nv_busy), .nv_write_done(ev[6]), .bus_collision(ev[7]),
		.voltage_detect(ev[8]), .timer_three_rollover(ev[9]), .capcomp_two_capture(ev[10]),
		.capcomp_two_match_t1(ev[11]), .capcomp_two_match_t3(ev[12]),
		.parallel_port_pending(par_pend), .adc_pending(adc_pend), .periph_irq(periph_irq));

	initial begin
		pclk = 1'b0;
	end
	always #5 pclk = ~pclk;

	task conclude();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task chk_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer; the request is held until pready is seen high at a rising edge.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat    = prdata;
		rerr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(rdat, exp);
	endtask

	task cmd(input logic [4:0] s);
		@(posedge pclk);
		fire <= 1'b1;
		sel  <= s;
		@(posedge pclk);
		fire <= 1'b0;
		cyc(3);
	endtask

	initial begin
		n_mismatch = 0;
		n_compared = 0;
		repeat (5000) @(posedge pclk);
		n_mismatch++;
		conclude();
	end

	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h00000000;
		fire    = 1'b0;
		sel     = 5'h00;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`PIF_OFF_FLAG1, `PIF_RST32);
		rd_chk(`PIF_OFF_FLAG2, `PIF_RST32);
		rd_chk(`PIF_OFF_EN1, `PIF_RST32);
		rd_chk(`PIF_OFF_EN2, `PIF_RST32);
		// With both capcomp units off after reset, a match must not set the flag.
		cmd(5'h02);
		rd_chk(`PIF_OFF_FLAG1, 32'h00000000);
		// Capcomp one in compare, capcomp two in capture, all individual enables off.
		apb(1'b1, `PIF_OFF_CTRL, 32'h00000013);
		for (int i = 0; i < 14; i++) begin
			cmd(i[4:0]);
			rd_chk((i < 4) ? `PIF_OFF_FLAG1 : `PIF_OFF_FLAG2, {24'h000000, MSK[i]});
			chk_bit(periph_irq, 1'b0);
			apb(1'b1, (i < 4) ? `PIF_OFF_FLAG1 : `PIF_OFF_FLAG2, 32'h00000000);
			rd_chk((i < 4) ? `PIF_OFF_FLAG1 : `PIF_OFF_FLAG2, 32'h00000000);
		end
		// The parallel flag position is never written with a one by software.
		// Capcomp one in PWM, capcomp two in compare on timer three.
		apb(1'b1, `PIF_OFF_CTRL, 32'h0000006B);
		cmd(5'h02);
		rd_chk(`PIF_OFF_FLAG1, 32'h00000000);
		cmd(5'h0C);
		rd_chk(`PIF_OFF_FLAG2, 32'h00000001);
		apb(1'b1, `PIF_OFF_FLAG2, 32'h00000000);
		cmd(5'h0B);
		rd_chk(`PIF_OFF_FLAG2, 32'h00000000);
		// Request gating by the individual, peripheral and global enables.
		apb(1'b1, `PIF_OFF_CTRL, 32'h00000003);
		apb(1'b1, `PIF_OFF_EN2, 32'h00000020);
		cmd(5'h05);
		chk_bit(periph_irq, 1'b1);
		apb(1'b1, `PIF_OFF_CTRL, 32'h00000001);
		cyc(3);
		chk_bit(periph_irq, 1'b0);
		apb(1'b1, `PIF_OFF_CTRL, 32'h00000003);
		cyc(3);
		chk_bit(periph_irq, 1'b1);
		rd_chk(`PIF_OFF_STAT, 32'h00000005);
		apb(1'b1, `PIF_OFF_CTRL, 32'h00000002);
		cyc(3);
		chk_bit(periph_irq, 1'b0);
		// With priority levels on, the gate alone lets the request through.
		apb(1'b1, `PIF_OFF_CTRL, 32'h00000006);
		cyc(3);
		chk_bit(periph_irq, 1'b1);
		apb(1'b1, `PIF_OFF_CTRL, 32'h00000003);
		apb(1'b1, `PIF_OFF_FLAG2, 32'h00000000);
		cyc(3);
		chk_bit(periph_irq, 1'b0);
		apb(1'b1, `PIF_OFF_EN2, 32'h00000000);
		// Parallel port and converter enables.
		apb(1'b1, `PIF_OFF_EN1, 32'h000000C0);
		rd_chk(`PIF_OFF_EN1, 32'h000000C0);
		cmd(5'h0F);
		chk_bit(periph_irq, 1'b1);
		cmd(5'h0F);
		chk_bit(periph_irq, 1'b0);
		cmd(5'h10);
		chk_bit(periph_irq, 1'b1);
		apb(1'b1, `PIF_OFF_EN1, 32'h00000000);
		cyc(3);
		chk_bit(periph_irq, 1'b0);
		cmd(5'h10);
		// A pending nonvolatile write reads its done flag as zero.
		cmd(5'h06);
		rd_chk(`PIF_OFF_FLAG2, 32'h00000010);
		cmd(5'h0E);
		rd_chk(`PIF_OFF_FLAG2, 32'h00000000);
		cmd(5'h0E);
		apb(1'b0, 12'h040, 32'h00000000);
		chk_bit(rerr, 1'b1);
		chk(rdat, 32'h00000000);
		conclude();
	end
endmodule
